// ---- logic/gpio_pkg.sv ----
// Constants, register map and mode codes for the GPIO port block
`default_nettype none

package gpio_pkg;

    // ========================================================
    // Register map: printed offsets are register indices,
    // byte address is four times the index
    localparam int unsigned NUM_PORTS_MAX = 4;
    localparam int unsigned REGS_PER_PORT = 4;
    localparam int unsigned IDX_W         = 10;
    localparam int unsigned ADDR_W        = 12;

    localparam logic [1:0] REG_DATA = 2'h0;
    localparam logic [1:0] REG_DIR  = 2'h1;
    localparam logic [1:0] REG_SEL1 = 2'h2;
    localparam logic [1:0] REG_SEL2 = 2'h3;

    // Rows: ports A..D; columns: data, direction, select one, two
    localparam logic [IDX_W-1:0] REG_IDX [NUM_PORTS_MAX][REGS_PER_PORT] =
        '{'{10'h096, 10'h097, 10'h098, 10'h099},
          '{10'h09a, 10'h09b, 10'h09c, 10'h09d},
          '{10'h09e, 10'h09f, 10'h0a0, 10'h0a1},
          '{10'h0a2, 10'h0a3, 10'h0a4, 10'h0a5}};

    // ========================================================
    // Reset values of one 8-bit port register
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] DIR_RST  = 8'hff;
    localparam logic [7:0] SEL1_RST = 8'h00;
    localparam logic [7:0] SEL2_RST = 8'h00;

    // ========================================================
    // Ports at or above this index own an alternate function
    localparam int unsigned FIRST_ALT_PORT = 2;
    // Samples a level must match before it requests service
    localparam int unsigned LEVEL_HOLD     = 2;

    // ========================================================
    // Pin modes
    typedef enum logic [3:0] {
        MODE_OUT    = 4'h1,
        MODE_IN     = 4'h2,
        MODE_DRAIN  = 4'h3,
        MODE_SOURCE = 4'h4,
        MODE_RSVD   = 4'h5,
        MODE_DUAL   = 4'h6,
        MODE_ALT    = 4'h7,
        MODE_LEVEL  = 4'h8,
        MODE_SINGLE = 4'h9
    } gpio_mode_t;

endpackage

`default_nettype wire

// ---- logic/gpio_ports.sv ----
// Four GPIO ports with per-pin modes and pin interrupts, APB slave
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module gpio_ports #(
    parameter int unsigned NUM_PORTS  = 4,
    parameter int unsigned PORT_WIDTH = 8
) (
    input  wire logic                     mclk,     // System clock
    input  wire logic                     sys_rst,  // Sync reset, high
    input  wire logic [11:0]              paddr,    // APB byte address
    input  wire logic                     psel,     // APB select
    input  wire logic                     penable,  // APB access phase
    input  wire logic                     pwrite,   // APB write
    input  wire logic [31:0]              pwdata,   // APB write data
    input  wire logic [3:0]               pstrb,    // APB byte strobes
    output logic      [31:0]              prdata,   // APB read data
    output logic                          pready,   // APB ready
    output logic                          pslverr,  // APB error
    input  wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_in,   // Pin levels
    output logic      [NUM_PORTS*PORT_WIDTH-1:0] pin_out,  // Pin drive
    output logic      [NUM_PORTS*PORT_WIDTH-1:0] pin_oe_n, // Drive, low
    input  wire logic [NUM_PORTS*PORT_WIDTH-1:0] alt_out,  // Alt drive
    input  wire logic [NUM_PORTS*PORT_WIDTH-1:0] alt_oe_n, // Alt enable
    output logic      [NUM_PORTS*PORT_WIDTH-1:0] irq       // Pin requests
);

    localparam int unsigned NP = NUM_PORTS * PORT_WIDTH;
    localparam int unsigned PW = PORT_WIDTH;

    // ========================================================
    // Parameter checks
    if (NUM_PORTS < 1 || NUM_PORTS > gpio_pkg::NUM_PORTS_MAX)
    begin : g_chk_ports
        $error("NUM_PORTS must be 1 to 4");
    end
    if (PORT_WIDTH < 1 || PORT_WIDTH > 8)
    begin : g_chk_width
        $error("PORT_WIDTH must be 1 to 8");
    end
    if (gpio_pkg::LEVEL_HOLD != 2)
    begin : g_chk_hold
        $error("Level filter is built for two samples");
    end

    // ========================================================
    // State
    typedef struct packed {
        logic [NP-1:0] dat;       // port_pin_data
        logic [NP-1:0] dir;       // port_pin_direction
        logic [NP-1:0] sel1;      // port_mode_select_one
        logic [NP-1:0] sel2;      // port_mode_select_two
        logic [NP-1:0] pin_meta;
        logic [NP-1:0] pin_sync;
        logic [NP-1:0] pin_prev;
        logic [NP-1:0] pend;
        logic [NP-1:0] irq;
        logic [NP-1:0] pout;
        logic [NP-1:0] poe_n;
        logic [31:0]   rdata;
        logic          ready;
        logic          slverr;
    } st_t;

    st_t s_reg;
    st_t s_next;

    // ========================================================
    // Functions
    function automatic gpio_pkg::gpio_mode_t pin_mode(
        input logic sel2,
        input logic sel1,
        input logic dir,
        input logic dat
    );
        gpio_pkg::gpio_mode_t m;
        m = gpio_pkg::MODE_IN;
        casez ({sel2, sel1, dir, dat})
            4'b000?: m = gpio_pkg::MODE_OUT;
            4'b001?: m = gpio_pkg::MODE_IN;
            4'b010?: m = gpio_pkg::MODE_DRAIN;
            4'b011?: m = gpio_pkg::MODE_SOURCE;
            4'b1000: m = gpio_pkg::MODE_RSVD;
            4'b1001: m = gpio_pkg::MODE_DUAL;
            4'b101?: m = gpio_pkg::MODE_ALT;
            4'b110?: m = gpio_pkg::MODE_LEVEL;
            4'b111?: m = gpio_pkg::MODE_SINGLE;
            default: m = gpio_pkg::MODE_IN;
        endcase
        return m;
    endfunction

    // Returns {hit, port, register}
    function automatic logic [4:0] reg_decode(input logic [11:0] a);
        logic [4:0] d;
        d = 5'h00;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            for (int r = 0; r < gpio_pkg::REGS_PER_PORT; r++)
            begin
                if (a[11:2] == gpio_pkg::REG_IDX[p][r] && a[1:0] == 2'h0)
                begin
                    d = {1'b1, 2'(p), 2'(r)};
                end
            end
        end
        return d;
    endfunction

    // ========================================================
    // Per-pin mode decode and helper masks
    gpio_pkg::gpio_mode_t md [NP];
    logic [NP-1:0] m_out, m_drain, m_source, m_rsvd, m_dual;
    logic [NP-1:0] m_alt, m_level, m_single, alt_port, lvl_match;

    for (genvar i = 0; i < NP; i++)
    begin : g_mode
        assign md[i] = pin_mode(s_reg.sel2[i], s_reg.sel1[i],
                                s_reg.dir[i], s_reg.dat[i]);
        assign m_out[i]    = (md[i] == gpio_pkg::MODE_OUT);
        assign m_drain[i]  = (md[i] == gpio_pkg::MODE_DRAIN);
        assign m_source[i] = (md[i] == gpio_pkg::MODE_SOURCE);
        assign m_rsvd[i]   = (md[i] == gpio_pkg::MODE_RSVD);
        assign m_dual[i]   = (md[i] == gpio_pkg::MODE_DUAL);
        assign m_alt[i]    = (md[i] == gpio_pkg::MODE_ALT);
        assign m_level[i]  = (md[i] == gpio_pkg::MODE_LEVEL);
        assign m_single[i] = (md[i] == gpio_pkg::MODE_SINGLE);
        assign alt_port[i] = ((i / PW) >= gpio_pkg::FIRST_ALT_PORT);
        // Two successive samples at the selected level
        assign lvl_match[i] = (s_reg.pin_sync[i] == s_reg.dat[i])
                           && (s_reg.pin_prev[i] == s_reg.dat[i]);
    end

    // ========================================================
    // Next state
    logic [4:0]    dec;
    logic          wr_go;
    logic [NP-1:0] rise;
    logic [NP-1:0] fall;
    logic [NP-1:0] clr;
    logic [NP-1:0] set_edge;

    assign dec   = reg_decode(paddr);
    assign wr_go = psel && penable && s_reg.ready && pwrite && dec[4]
                && pstrb[0];
    assign rise  = s_reg.pin_sync & ~s_reg.pin_prev;
    assign fall  = ~s_reg.pin_sync & s_reg.pin_prev;

    always_comb
    begin
        s_next = s_reg;
        clr    = '0;

        // Pin sampling: two stages, then one history stage
        s_next.pin_meta = pin_in;
        s_next.pin_sync = s_reg.pin_meta;
        s_next.pin_prev = s_reg.pin_sync;

        // APB answer one cycle after the setup cycle
        s_next.ready  = psel && !penable;
        s_next.slverr = psel && !penable && !dec[4];
        s_next.rdata  = '0;
        if (psel && !penable && dec[4])
        begin
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                if (dec[3:2] == 2'(p))
                begin
                    case (dec[1:0])
                        gpio_pkg::REG_DATA:
                            s_next.rdata[PW-1:0] =
                                s_reg.pin_sync[p*PW +: PW];
                        gpio_pkg::REG_DIR:
                            s_next.rdata[PW-1:0] = s_reg.dir[p*PW +: PW];
                        gpio_pkg::REG_SEL1:
                            s_next.rdata[PW-1:0] = s_reg.sel1[p*PW +: PW];
                        gpio_pkg::REG_SEL2:
                            s_next.rdata[PW-1:0] = s_reg.sel2[p*PW +: PW];
                        default:
                            s_next.rdata = '0;
                    endcase
                end
            end
        end

        // Register writes
        if (wr_go)
        begin
            for (int p = 0; p < NUM_PORTS; p++)
            begin
                if (dec[3:2] == 2'(p))
                begin
                    case (dec[1:0])
                        gpio_pkg::REG_DATA:
                        begin
                            s_next.dat[p*PW +: PW] = pwdata[PW-1:0];
                            clr[p*PW +: PW] = pwdata[PW-1:0];
                        end
                        gpio_pkg::REG_DIR:
                            s_next.dir[p*PW +: PW] = pwdata[PW-1:0];
                        gpio_pkg::REG_SEL1:
                            s_next.sel1[p*PW +: PW] = pwdata[PW-1:0];
                        gpio_pkg::REG_SEL2:
                            s_next.sel2[p*PW +: PW] = pwdata[PW-1:0];
                        default:
                            s_next.dat = s_reg.dat;
                    endcase
                end
            end
        end

        // Edge requests: set wins over a clear in the same cycle
        set_edge = (m_dual & (rise | fall))
                 | (m_single & ((s_reg.dat & rise)
                              | (~s_reg.dat & fall)));
        s_next.pend = ((s_reg.pend & ~clr) | set_edge)
                    & (m_dual | m_single);
        // One request line per pin
        s_next.irq = s_next.pend | (m_level & lvl_match);

        // Pin drivers
        for (int i = 0; i < NP; i++)
        begin
            s_next.pout[i]  = 1'b0;
            s_next.poe_n[i] = 1'b1;
            case (md[i])
                gpio_pkg::MODE_OUT:
                begin
                    s_next.pout[i]  = s_reg.dat[i];
                    s_next.poe_n[i] = 1'b0;
                end
                gpio_pkg::MODE_DRAIN:
                begin
                    s_next.pout[i]  = 1'b0;
                    s_next.poe_n[i] = s_reg.dat[i];
                end
                gpio_pkg::MODE_SOURCE:
                begin
                    s_next.pout[i]  = 1'b1;
                    s_next.poe_n[i] = !s_reg.dat[i];
                end
                gpio_pkg::MODE_ALT:
                begin
                    if (alt_port[i])
                    begin
                        s_next.pout[i]  = alt_out[i];
                        s_next.poe_n[i] = alt_oe_n[i];
                    end
                end
                // Input, reserved, A/B alternate and interrupt modes float
                default:
                begin
                    s_next.pout[i]  = 1'b0;
                    s_next.poe_n[i] = 1'b1;
                end
            endcase
        end

        if (sys_rst)
        begin
            s_next.dat   = {NUM_PORTS{gpio_pkg::DATA_RST[PW-1:0]}};
            s_next.dir   = {NUM_PORTS{gpio_pkg::DIR_RST[PW-1:0]}};
            s_next.sel1  = {NUM_PORTS{gpio_pkg::SEL1_RST[PW-1:0]}};
            s_next.sel2  = {NUM_PORTS{gpio_pkg::SEL2_RST[PW-1:0]}};
            s_next.pend  = '0;
            s_next.irq   = '0;
            s_next.pout  = '0;
            s_next.poe_n = '1;
            s_next.rdata = '0;
            s_next.ready = 1'b0;
            s_next.slverr = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        s_reg <= s_next;
    end

    assign prdata   = s_reg.rdata;
    assign pready   = s_reg.ready;
    assign pslverr  = s_reg.slverr;
    assign pin_out  = s_reg.pout;
    assign pin_oe_n = s_reg.poe_n;
    assign irq      = s_reg.irq;

    // ========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_reset_idle;
        disable iff (1'b0)
        sys_rst |=> (pin_oe_n == '1) && (irq == '0) && (s_reg.dir == '1);
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("Pins not idle inputs after reset");
    property p_push_pull;
        ##1 ((pin_oe_n & $past(m_out)) == '0)
            && (((pin_out ^ $past(s_reg.dat)) & $past(m_out)) == '0);
    endproperty
    a_push_pull: assert property (p_push_pull)
        else $error("Output mode does not drive data bit");
    property p_drain_source;
        ##1 (((pin_oe_n ^ $past(s_reg.dat)) & $past(m_drain)) == '0)
            && (((pin_oe_n ^ ~$past(s_reg.dat)) & $past(m_source)) == '0);
    endproperty
    a_drain_source: assert property (p_drain_source)
        else $error("Open drain or source enable wrong");
    property p_float;
        ##1 ((~pin_oe_n & ($past(m_level | m_dual | m_single | m_rsvd)
              | ($past(m_alt) & ~alt_port))) == '0);
    endproperty
    a_float: assert property (p_float)
        else $error("Driver on in a floating mode");
    property p_alt_follow;
        ##1 (((pin_out ^ $past(alt_out)) & $past(m_alt) & alt_port) == '0);
    endproperty
    a_alt_follow: assert property (p_alt_follow)
        else $error("Alternate drive not passed to pin");
    property p_level_req;
        ##1 (((irq ^ $past(lvl_match)) & $past(m_level)) == '0);
    endproperty
    a_level_req: assert property (p_level_req)
        else $error("Level request not tied to two matching samples");
    property p_edge_hold;
        ##1 (($past(s_reg.pend & m_single & ~clr & m_single) & ~irq) == '0);
    endproperty
    a_edge_hold: assert property (p_edge_hold)
        else $error("Latched edge request lost without clear");
    property p_edge_clear;
        ##1 (($past(clr & (m_dual | m_single) & ~set_edge) & irq) == '0);
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("Write of one did not clear edge request");
    property p_read_pins;
        (psel && !penable && dec[4] && !pwrite && dec[1:0] == 2'h0)
            |=> pready && (prdata[PW-1:0] ==
                PW'($past(s_reg.pin_sync) >> (PW * $past(dec[3:2]))));
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("Data read does not return pin samples");

endmodule

`default_nettype wire

// ---- verif/gpio_pin_env.sv ----
// External pin model: drivers, pull resistors and floating lines
`timescale 1ns/10ps
`default_nettype none

module gpio_pin_env (
    input  wire logic        mclk,      // System clock
    input  wire logic [31:0] pin_out,   // Block drive value
    input  wire logic [31:0] pin_oe_n,  // Block drive enable, low
    input  wire logic [31:0] ext_val,   // External driver value
    input  wire logic [31:0] ext_en,    // External driver on
    input  wire logic [31:0] pull_up,   // Pull-up fitted
    output logic      [31:0] pin_in     // Resolved pin level
);
    logic [31:0] last_reg = 32'h0;

    // A floating pin without pull keeps toggling, never a stale level
    always_comb
    begin
        for (int i = 0; i < 32; i++)
        begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pull_up[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = ~last_reg[i];
        end
    end

    always_ff @(posedge mclk)
        last_reg <= pin_in;
endmodule
`default_nettype wire

// ---- verif/gpio_ports_tb.sv ----
// Self-checking testbench for the GPIO port block
`timescale 1ns/10ps
`default_nettype none

module gpio_ports_tb;
    logic        mclk;
    logic        sys_rst;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] pin_in;
    logic [31:0] pin_out;
    logic [31:0] pin_oe_n;
    logic [31:0] alt_out;
    logic [31:0] alt_oe_n;
    logic [31:0] irq;
    logic [31:0] ext_val;
    logic [31:0] ext_en;
    logic [31:0] pull_up;
    logic [31:0] rd;
    logic        err;
    int          miscompares;
    int          total_checks;

    gpio_ports dut_u (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .alt_out(alt_out), .alt_oe_n(alt_oe_n),
        .irq(irq));

    gpio_pin_env env_u (.mclk(mclk), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .ext_val(ext_val), .ext_en(ext_en),
        .pull_up(pull_up), .pin_in(pin_in));

    // ========================================================
    // Helpers
    task automatic conclude;
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 20)
        begin
            $display("Error pready expected 1 seen %b", pready);
            miscompares++;
            conclude();
        end
        else
        begin
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    function automatic logic [11:0] addr(input int p, input int r);
        return {gpio_pkg::REG_IDX[p][r], 2'h0};
    endfunction

    task automatic wr(input int p, input int r, input logic [7:0] v);
        apb(1'b1, addr(p, r), {24'h0, v});
    endtask

    task automatic rdreg(input int p, input int r);
        apb(1'b0, addr(p, r), 32'h0);
    endtask

    task automatic set_mode(input int p, input logic [3:0] c);
        if (c[3] && c[2:1] != 2'h1 && (c[2:1] == 2'h3 || c == 4'h9))
            wr(p, gpio_pkg::REG_DATA, 8'hff);
        wr(p, gpio_pkg::REG_DATA, {8{c[0]}});
        wr(p, gpio_pkg::REG_DIR, {8{c[1]}});
        wr(p, gpio_pkg::REG_SEL1, {8{c[2]}});
        wr(p, gpio_pkg::REG_SEL2, {8{c[3]}});
    endtask

    task automatic drive_ext(input int p, input logic [7:0] v,
                             input logic [7:0] en);
        @(posedge mclk);
        ext_val[p*8+:8] <= v;
        ext_en[p*8+:8]  <= en;
    endtask

    task automatic peek(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wait_irq(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        @(negedge mclk);
        while ((irq & m) !== v && n < 12)
        begin
            @(negedge mclk);
            n++;
        end
        total_checks++;
        if (n == 12)
        begin
            $display("Error irq expected %h seen %h", v, irq & m);
            miscompares++;
            conclude();
        end
    endtask

    // Expected {oe_n, out} of one port for a mode code
    function automatic logic [15:0] exp_pins(input logic [3:0] c,
                                             input int p);
        case (c)
            4'h0, 4'h1: return {8'h00, {8{c[0]}}};
            4'h4: return {8'h00, 8'h00};
            4'h7: return {8'h00, 8'hff};
            4'ha, 4'hb: if (p >= 2)
                return {alt_oe_n[p*8+:8], alt_out[p*8+:8]};
            default: ;
        endcase
        return {8'hff, 8'h00};
    endfunction

    // ========================================================
    // Scenarios
    task automatic t_reset;
        for (int p = 0; p < 4; p++)
        begin
            rdreg(p, gpio_pkg::REG_DIR);
            check("direction", 32'hff, rd);
            rdreg(p, gpio_pkg::REG_SEL1);
            check("select one", 32'h0, rd);
            rdreg(p, gpio_pkg::REG_SEL2);
            check("select two", 32'h0, rd);
        end
        check("oe_n", 32'hffffffff, pin_oe_n);
        check("irq", 32'h0, irq);
    endtask

    task automatic t_drive;
        logic [15:0] e;
        for (int p = 0; p < 4; p += 2)
        begin
            for (int c = 0; c < 16; c++)
            begin
                set_mode(p, 4'(c));
                peek(4);
                e = exp_pins(4'(c), p);
                check("oe_n", 32'(e[15:8]), 32'(pin_oe_n[p*8+:8]));
                check("out", 32'(e[7:0] & ~e[15:8]),
                      32'(pin_out[p*8+:8] & ~pin_oe_n[p*8+:8]));
            end
            set_mode(p, 4'h2);
        end
    endtask

    task automatic t_read;
        set_mode(0, 4'h2);
        drive_ext(0, 8'h5a, 8'hff);
        peek(4);
        rdreg(0, gpio_pkg::REG_DATA);
        check("data read", 32'h5a, rd);
        drive_ext(0, 8'h00, 8'h00);
        set_mode(0, 4'h0);
        wr(0, gpio_pkg::REG_DATA, 8'ha5);
        peek(4);
        rdreg(0, gpio_pkg::REG_DATA);
        check("data read", 32'ha5, rd);
        wr(0, gpio_pkg::REG_DIR, 8'hff);
        peek(4);
        rdreg(0, gpio_pkg::REG_DATA);
        check("data read", 32'hff, rd);
    endtask

    task automatic t_level;
        for (int l = 0; l < 2; l++)
        begin
            drive_ext(1, ~{8{l[0]}}, 8'hff);
            set_mode(1, {3'h6, l[0]});
            peek(8);
            drive_ext(1, {8{l[0]}}, 8'hff);
            drive_ext(1, ~{8{l[0]}}, 8'hff);
            repeat (6)
            begin
                peek(1);
                check("irq", 32'h0, irq);
            end
            drive_ext(1, {8{l[0]}}, 8'hff);
            wait_irq(32'h0000ff00, 32'h0000ff00);
            peek(5);
            check("irq", 32'h0000ff00, irq);
            drive_ext(1, ~{8{l[0]}}, 8'hff);
            wait_irq(32'h0000ff00, 32'h0);
        end
        set_mode(1, 4'h2);
    endtask

    task automatic t_edge;
        drive_ext(3, 8'h00, 8'hff);
        set_mode(3, 4'hf);
        peek(4);
        wr(3, gpio_pkg::REG_DATA, 8'hff);
        wait_irq(32'hff000000, 32'h0);
        drive_ext(3, 8'hff, 8'hff);
        wait_irq(32'hff000000, 32'hff000000);
        drive_ext(3, 8'h00, 8'hff);
        peek(6);
        check("irq", 32'hff000000, irq);
        wr(3, gpio_pkg::REG_DATA, 8'h00);
        peek(4);
        check("irq", 32'hff000000, irq);
        wr(3, gpio_pkg::REG_DATA, 8'hff);
        wait_irq(32'hff000000, 32'h0);
        set_mode(3, 4'he);
        drive_ext(3, 8'hff, 8'hff);
        peek(6);
        check("irq", 32'h0, irq);
        drive_ext(3, 8'h00, 8'hff);
        wait_irq(32'hff000000, 32'hff000000);
        set_mode(3, 4'h9);
        wait_irq(32'hff000000, 32'h0);
        drive_ext(3, 8'hff, 8'hff);
        wait_irq(32'hff000000, 32'hff000000);
        wr(3, gpio_pkg::REG_DATA, 8'hff);
        wait_irq(32'hff000000, 32'h0);
        drive_ext(3, 8'h00, 8'hff);
        wait_irq(32'hff000000, 32'hff000000);
    endtask

    task automatic t_unmapped;
        apb(1'b0, 12'h000, 32'h0);
        check("slverr", 32'h1, 32'(err));
        apb(1'b0, addr(0, 0) | 12'h001, 32'h0);
        check("slverr", 32'h1, 32'(err));
        check("rdata", 32'h0, rd);
        pstrb <= 4'h0;
        wr(0, gpio_pkg::REG_DIR, 8'h00);
        pstrb <= 4'hf;
        rdreg(0, gpio_pkg::REG_DIR);
        check("direction", 32'hff, rd);
    endtask

    // ========================================================
    // Clock, reset and sequence
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial
    begin
        sys_rst      = 1'b1;
        paddr        = 12'h000;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        pwdata       = 32'h0;
        pstrb        = 4'hf;
        alt_out      = 32'h00a50000;
        alt_oe_n     = 32'h000f0000;
        ext_val      = 32'h0;
        ext_en       = 32'h0;
        pull_up      = 32'hffffffff;
        miscompares  = 0;
        total_checks = 0;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_drive();
        t_read();
        t_level();
        t_edge();
        t_unmapped();
        conclude();
    end
endmodule
`default_nettype wire
